// ===== adc_readout_pkg.sv
// shared constants and types for the converter readout block
// assumes a 200 MHz system clock and an external host-driven shift clock
package adc_readout_pkg;
  localparam int RESULT_BITS = 12;
  localparam int SYS_CLK_MHZ = 200;
  // conversion time per grade, in ns (slow, middle, fast)
  localparam int CONVERT_STROBE_TIME_SLOW_NS = 8000;
  localparam int CONVERT_STROBE_TIME_MID_NS  = 3000;
  localparam int CONVERT_STROBE_TIME_FAST_NS = 1500;
  localparam int CONVERT_STROBE_CYC_SLOW = (CONVERT_STROBE_TIME_SLOW_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int CONVERT_STROBE_CYC_MID  = (CONVERT_STROBE_TIME_MID_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int CONVERT_STROBE_CYC_FAST = (CONVERT_STROBE_TIME_FAST_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int FIFO_DEPTH = 8;
  localparam logic [1:0] GRADE_SLOW = 2'h0;
  localparam logic [1:0] GRADE_MID  = 2'h1;
  localparam logic [1:0] GRADE_FAST = 2'h2;
  typedef struct packed {
    logic [RESULT_BITS-1:0] code;
  } result_word_t;
  typedef enum logic [1:0] {
    ST_SLEEP   = 2'b00,
    ST_CONVERT = 2'b01,
    ST_DONE    = 2'b10
  } convert_strobe_state_t;
endpackage

// ===== adc_serial_conversion_readout.sv
// converter control and serial readout: sys domain times conversions,
// shift-clock domain drives the three-state serial result pin
// assumes the host keeps strobe timing; shift clock may stop between frames
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module result_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             do_wr;
  logic             do_rd;

  always_comb begin
    in_ready    = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    out_valid   = wr_ptr != rd_ptr;
    out_data    = mem[rd_ptr[AW-1:0]];
    do_wr       = in_valid && in_ready;
    do_rd       = out_valid && out_ready;
    next_wr_ptr = do_wr ? wr_ptr + (AW+1)'(1) : wr_ptr;
    next_rd_ptr = do_rd ? rd_ptr + (AW+1)'(1) : rd_ptr;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule // result_fifo

////////////////////////////////////////////////////////////////////////////////
module adc_serial_conversion_readout
  import adc_readout_pkg::*;
#(
  parameter int CONVERT_STROBE_CYC_SLOW_P = CONVERT_STROBE_CYC_SLOW,
  parameter int CONVERT_STROBE_CYC_MID_P  = CONVERT_STROBE_CYC_MID,
  parameter int CONVERT_STROBE_CYC_FAST_P = CONVERT_STROBE_CYC_FAST
) (
  // system clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         sys_rst,
  // speed grade strap and sampled analog code
  input  wire logic [1:0]                   speed_grade,
  input  wire adc_readout_pkg::result_word_t sample_code,
  // host pins
  input  wire logic                         convert_strobe,
  input  wire logic                         shift_clk,
  output logic                              serial_result_out,
  output logic                              serial_result_oe,
  // status
  output logic                              powered_down,
  output logic                              result_overflow
);
  import adc_readout_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // system domain: strobe sync and conversion timer
  logic        strobe_s1, strobe_s2, strobe_s3;
  convert_strobe_state_t state, next_state;
  logic [15:0] timer, next_timer;
  logic [15:0] convert_strobe_len;
  logic        next_powered_down;
  logic        next_overflow;
  logic        push_valid;
  logic        push_ready;
  result_word_t captured, next_captured;
  logic        pop_valid;
  logic        pop_ready;
  result_word_t pop_word;

  always_comb begin
    unique case (speed_grade)
      GRADE_MID:  convert_strobe_len = 16'(CONVERT_STROBE_CYC_MID_P);
      GRADE_FAST: convert_strobe_len = 16'(CONVERT_STROBE_CYC_FAST_P);
      default:    convert_strobe_len = 16'(CONVERT_STROBE_CYC_SLOW_P);
    endcase
  end

  always_comb begin
    next_state        = state;
    next_timer        = timer;
    next_captured     = captured;
    next_powered_down = powered_down;
    next_overflow     = result_overflow;
    push_valid        = 1'b0;
    unique case (state)
      ST_SLEEP: begin
        if (strobe_s2 && !strobe_s3) begin
          next_state        = ST_CONVERT;
          next_timer        = convert_strobe_len - 16'h0001;
          next_powered_down = 1'b0;
          next_captured     = sample_code;
        end else if (!strobe_s2) begin
          next_powered_down = 1'b0; // acquiring while strobe is low
        end
      end
      ST_CONVERT: begin
        if (timer == 16'h0000) begin
          next_state = ST_DONE;
        end else begin
          next_timer = timer - 16'h0001;
        end
      end
      ST_DONE: begin
        push_valid = 1'b1;
        // a full queue drops the word rather than stalling the converter
        if (!push_ready) begin
          next_overflow = 1'b1;
        end
        next_state        = ST_SLEEP;
        next_powered_down = 1'b1;
      end
      default: next_state = ST_SLEEP;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      strobe_s1       <= 1'b0;
      strobe_s2       <= 1'b0;
      strobe_s3       <= 1'b0;
      state           <= ST_SLEEP;
      timer           <= 16'h0000;
      captured        <= '0;
      powered_down    <= 1'b1;
      result_overflow <= 1'b0;
    end else begin
      strobe_s1       <= convert_strobe;
      strobe_s2       <= strobe_s1;
      strobe_s3       <= strobe_s2;
      state           <= next_state;
      timer           <= next_timer;
      captured        <= next_captured;
      powered_down    <= next_powered_down;
      result_overflow <= next_overflow;
    end
  end

  result_fifo #(
    .WIDTH (RESULT_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk_sys),
    .rst       (sys_rst),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (captured),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // word handoff to link side: held register plus toggle request
  result_word_t held, next_held;
  logic         req_tgl, next_req_tgl;
  logic         ack_tgl, next_ack_tgl;
  logic         ack_s1, ack_s2;
  logic         busy, next_busy;

  always_comb begin
    next_held    = held;
    next_req_tgl = req_tgl;
    next_busy    = busy;
    pop_ready    = 1'b0;
    if (busy) begin
      if (ack_s2 == req_tgl) begin
        next_busy = 1'b0;
      end
    end else if (pop_valid) begin
      pop_ready    = 1'b1;
      next_held    = pop_word;
      next_req_tgl = !req_tgl;
      next_busy    = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      held    <= '0;
      req_tgl <= 1'b0;
      ack_s1  <= 1'b0;
      ack_s2  <= 1'b0;
      busy    <= 1'b0;
    end else begin
      held    <= next_held;
      req_tgl <= next_req_tgl;
      ack_s1  <= ack_tgl;
      ack_s2  <= ack_s1;
      busy    <= next_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link domain on the shift clock falling edge
  // the clock stops between frames, so the top bit and the pin enable are
  // also driven straight from the strobe level, which needs no clock edge
  logic                   req_l1, req_l2, req_l3;
  result_word_t           frame, next_frame;
  logic [RESULT_BITS-1:0] shreg, next_shreg;
  logic                   in_frame, next_in_frame;
  logic [3:0]             bit_cnt, next_bit_cnt;

  always_comb begin
    next_ack_tgl  = ack_tgl;
    next_frame    = frame;
    next_shreg    = shreg;
    next_in_frame = in_frame;
    next_bit_cnt  = bit_cnt;
    if (req_l2 != req_l3) begin
      next_frame   = held;
      next_ack_tgl = req_l2;
    end
    if (convert_strobe) begin
      next_in_frame = 1'b0;
    end else if (!in_frame) begin
      // first falling edge in frame moves past the top bit
      next_in_frame = 1'b1;
      next_shreg    = {frame.code[RESULT_BITS-2:0], 1'b0};
      next_bit_cnt  = 4'h1;
    end else begin
      next_shreg = {shreg[RESULT_BITS-2:0], 1'b0}; // zeros shift
      if (bit_cnt != 4'(RESULT_BITS)) begin
        next_bit_cnt = bit_cnt + 4'h1;
      end
    end
  end

  always_ff @(negedge shift_clk) begin
    req_l1   <= req_tgl;
    req_l2   <= req_l1;
    req_l3   <= req_l2;
    ack_tgl  <= next_ack_tgl;
    frame    <= next_frame;
    shreg    <= next_shreg;
    in_frame <= next_in_frame;
    bit_cnt  <= next_bit_cnt;
  end

  // enable follows strobe low; strobe rise releases the pin
  // before the first falling edge, the top bit is shown directly
  always_comb begin
    serial_result_oe  = !convert_strobe;
    serial_result_out = convert_strobe ? 1'b0 :
                        (in_frame ? shreg[RESULT_BITS-1] : frame.code[RESULT_BITS-1]);
  end
endmodule // adc_serial_conversion_readout

// ===== adc_readout_checker.sv
// port checker for the readout top
// assumes 8-cycle conversions and a bench that holds the code steady
`timescale 1ns/1ps
module adc_readout_checker
  import adc_readout_pkg::*;
(
  input wire logic         clk_sys,
  input wire logic         sys_rst,
  input wire logic [1:0]   speed_grade,
  input wire result_word_t sample_code,
  input wire logic         convert_strobe,
  input wire logic         shift_clk,
  input wire logic         serial_result_out,
  input wire logic         serial_result_oe,
  input wire logic         powered_down,
  input wire logic         result_overflow
);
  result_word_t held;
  logic [3:0]   fall_cnt;
  always_ff @(posedge clk_sys)
    if (convert_strobe && !powered_down) held <= sample_code;
  // strobe is async to the shift clock, so it clears the count itself
  always_ff @(negedge shift_clk or posedge convert_strobe)
    if (convert_strobe) fall_cnt <= 4'h0;
    else if (fall_cnt != 4'hF) fall_cnt <= fall_cnt + 4'h1;
  chk_oe_follows: assert property (@(posedge clk_sys) disable iff (sys_rst)
    serial_result_oe == !convert_strobe) else $error("oe wrong");
  chk_hiz_on_rise: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(convert_strobe) |-> !serial_result_oe) else $error("no release");
  chk_wake_on_start: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(convert_strobe) |-> ##[1:8] !powered_down) else $error("no start");
  chk_no_spurious: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (convert_strobe && $past(convert_strobe, 8) && powered_down) |=> powered_down)
    else $error("stray start");
  chk_auto_sleep: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ($fell(powered_down) && convert_strobe) |-> ##[4:20] powered_down) else $error("no sleep");
  chk_msb_on_fall: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(convert_strobe) |-> serial_result_out == held.code[11]) else $error("top bit");
  chk_fall_only: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!convert_strobe && $past(!convert_strobe) && $changed(serial_result_out))
    |-> $fell(shift_clk)) else $error("off-edge change");
  chk_serial_order: assert property (@(negedge shift_clk) disable iff (sys_rst)
    !convert_strobe |-> serial_result_out ==
    (fall_cnt < 4'hC ? held.code[4'hB - fall_cnt] : 1'b0)) else $error("bit order");
  cover property (@(posedge clk_sys) $fell(convert_strobe));
  cover property (@(posedge clk_sys) $rose(powered_down));
  cover property (@(posedge clk_sys) $rose(result_overflow));
endmodule // adc_readout_checker

// ===== adc_host_model.sv
// host model: strobe, shift clock, samples the serial pin
// assumes conversions finish well inside 300 ns
`timescale 1ns/1ps
module adc_host_model (
  // host pins
  output logic      convert_strobe,
  output logic      shift_clk,
  input wire logic  serial_result_out
);
  logic [13:0] got;
  initial begin
    convert_strobe = 1'b0;
    shift_clk = 1'b0;
    got = 14'h0;
  end
  task automatic pulses(input int n);
    repeat (n) begin
      #16 got = {got[12:0], serial_result_out};
      shift_clk = 1'b1;
      #16 shift_clk = 1'b0;
    end
  endtask
  // odd offset keeps host edges off the system clock edges
  task automatic start();
    #0.3 convert_strobe = 1'b1;
    #300;
  endtask
  task automatic finish(input int pre, input int bits);
    #0.3 pulses(pre);
    #20 convert_strobe = 1'b0;
    got = 14'h0;
    pulses(bits);
    #600;
  endtask
endmodule // adc_host_model

// ===== test_adc_serial_conversion_readout.sv
// bench for the readout block: random codes and grades, then a fill
// assumes every grade shortened to 8 cycles
`timescale 1ns/1ps
module test_adc_serial_conversion_readout;
  import adc_readout_pkg::*;
  logic         clk_sys = 1'b0;
  logic         sys_rst = 1'b1;
  logic [1:0]   speed_grade = 2'h0;
  result_word_t sample_code = '0;
  logic         convert_strobe, shift_clk, serial_result_out;
  logic         serial_result_oe, powered_down, result_overflow;
  int           failures = 0;
  int           checks = 0;
  logic [31:0]  seed = 32'h2E;
  always #2.5 clk_sys = ~clk_sys;
  adc_serial_conversion_readout #(.CONVERT_STROBE_CYC_SLOW_P(8), .CONVERT_STROBE_CYC_MID_P(8),
    .CONVERT_STROBE_CYC_FAST_P(8)) i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .speed_grade(speed_grade), .sample_code(sample_code), .convert_strobe(convert_strobe),
    .shift_clk(shift_clk), .serial_result_out(serial_result_out),
    .serial_result_oe(serial_result_oe), .powered_down(powered_down),
    .result_overflow(result_overflow));
  adc_host_model i_host (.convert_strobe(convert_strobe), .shift_clk(shift_clk),
    .serial_result_out(serial_result_out));
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [13:0] expect_stream(input logic [11:0] c);
    return {c, 2'b00};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check_word(input string n, input logic [13:0] e, input logic [13:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check_flag(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic wait_sleep();
    for (int i = 0; i < 100 && powered_down !== 1'b1; i++)
      @(posedge clk_sys);
    check_flag("powered_down", 1'b1, powered_down);
    if (powered_down !== 1'b1) report_and_stop();
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    // unreset link flops miss the first toggle, so flush them with a spare frame
    i_host.start();
    i_host.finish(8, 0);
    for (int i = 0; i < 8; i++) begin
      seed = xorshift(seed);
      @(posedge clk_sys);
      #1 sample_code.code = i == 0 ? 12'hFFF : i == 1 ? 12'h000 : seed[11:0];
      speed_grade = i < 4 ? i[1:0] : seed[13:12];
      i_host.start();
      wait_sleep();
      i_host.finish(8, 14);
      check_word("stream", expect_stream(sample_code.code), i_host.got);
      check_flag("overflow", 1'b0, result_overflow);
    end
    // no shift clock, so words pile up until the buffer refuses
    repeat (12) begin
      i_host.start();
      wait_sleep();
      i_host.finish(0, 0);
    end
    check_flag("overflow", 1'b1, result_overflow);
    report_and_stop();
  end
endmodule // test_adc_serial_conversion_readout
bind adc_serial_conversion_readout adc_readout_checker i_chk (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .speed_grade(speed_grade), .sample_code(sample_code),
  .convert_strobe(convert_strobe), .shift_clk(shift_clk),
  .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
  .powered_down(powered_down), .result_overflow(result_overflow));
